// >>> verilog/dims_pkg.sv
// constants, encodings and register map of the DDR2 device-side model
package dims_pkg;
  // ==========================================================
  // link geometry
  localparam int ROW_W = 14;
  localparam int COL_W = 10;
  localparam int DQ_W = 16;
  localparam int LINK_W = 23;
  localparam int DATA_W = 20;

  // ==========================================================
  // command encodings {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_RSV = 3'h6,
    CMD_NOP = 3'h7
  } dims_cmd_e;

  // bank address selecting the mode register written
  localparam logic [1:0] BA_MR = 2'h0;
  localparam logic [1:0] BA_EMR1 = 2'h1;
  localparam logic [1:0] BA_EMR2 = 2'h2;
  localparam logic [1:0] BA_EMR3 = 2'h3;

  // ==========================================================
  // initialisation tracker states
  typedef enum logic [3:0] {
    I_PWR   = 4'h0,
    I_PALL1 = 4'h1,
    I_EMR2  = 4'h2,
    I_EMR3  = 4'h3,
    I_EMR1  = 4'h4,
    I_MRDLL = 4'h5,
    I_PALL2 = 4'h6,
    I_REF1  = 4'h7,
    I_REF2  = 4'h8,
    I_MROP  = 4'h9,
    I_OCD   = 4'hA,
    I_READY = 4'hB
  } dims_init_e;

  // ==========================================================
  // address field positions
  localparam int A_AP = 10;
  localparam int A_DLL_RST = 8;
  localparam int A_DLL_DIS = 0;
  localparam int A_RSV12 = 12;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int EMR_AL_LSB = 3;
  localparam int EMR_RTT0 = 2;
  localparam int EMR_RTT1 = 6;
  localparam int EMR_OCD_LSB = 7;
  localparam int EMR_RDQS = 11;
  localparam logic [2:0] MR_BL8_CODE = 3'h3;
  localparam logic [2:0] OCD_EXIT = 3'h0;
  localparam logic [2:0] OCD_DEFAULT = 3'h7;

  // ==========================================================
  // timing: DLL lock wait counted in link clock cycles
  localparam logic [7:0] DLL_LOCK_CK = 8'hC8;

  // ==========================================================
  // register map (byte addresses) and fields
  localparam int AVS_AW = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_MR = 5'h08;
  localparam logic [4:0] REG_EMR1 = 5'h0C;
  localparam logic [4:0] REG_EMR2 = 5'h10;
  localparam logic [4:0] REG_EMR3 = 5'h14;
  localparam logic [4:0] REG_MASKCNT = 5'h18;
  localparam int CTRL_LINK_EN = 0;
  localparam logic CTRL_LINK_EN_RST = 1'b1;
  localparam int ST_READY = 0;
  localparam int ST_SEQ_ERR = 1;
  localparam int ST_EARLY_ERR = 2;
  localparam int ST_TERM = 3;
  localparam int ST_DLL_LOCK = 4;
  localparam int ST_RDQS = 5;
  localparam int ST_BURST = 6;
  localparam int ST_INIT_LSB = 8;
endpackage

// >>> verilog/dims_sync.sv
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module dims_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import dims_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dims_sync_s;

  dims_sync_s s_r;
  dims_sync_s s_nxt;

  // ==========================================================
  // state
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;
endmodule

// >>> verilog/dims_burst_col.sv
// column of a given beat inside a wrapped burst
`timescale 1ns/1ps
module dims_burst_col #(
  parameter int CW = 10
) (
  input wire logic [CW-1:0] start_col,
  input wire logic [2:0] beat,
  input wire logic bl8,
  input wire logic interleave,
  output logic [CW-1:0] col
);
  import dims_pkg::*;

  if (CW < 3) begin : g_bad_cw
    $error("dims_burst_col: CW must be at least 3");
  end

  logic [2:0] low;

  // ==========================================================
  // wrap inside the burst-length block
  always_comb begin
    low = start_col[2:0] + beat;
    if (interleave) begin
      low = start_col[2:0] ^ beat;
    end
    col = start_col;
    if (bl8) begin
      col[2:0] = low;
    end else begin
      col[1:0] = low[1:0];
    end
  end
endmodule

// >>> verilog/dims_top.sv
// DDR2 device-side model: command decode, init tracking, bursts, masks, ODT
// Operation
// - drop write beats whose mask is high
// - mask sampled on both strobe edges
// - lower mask gates low byte, upper high
// - x8 mask pin doubles as read strobe
// - ODT ignored when termination disabled
// - bursts of four or eight, programmed order
// - activate opens row, then read or write
// - column address sets start and auto-precharge
// - mode writes leave array data intact
`timescale 1ns/1ps
module dims_top #(
  parameter bit X8 = 1'b0,
  parameter int MEM_AW = 10
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [dims_pkg::AVS_AW-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic CK,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [1:0] BA,
  input wire logic [dims_pkg::ROW_W-1:0] A,
  input wire logic ODT,
  input wire logic [dims_pkg::DQ_W-1:0] DQ_I,
  output logic [dims_pkg::DQ_W-1:0] DQ_O,
  output logic DQ_OE,
  input wire logic [1:0] DQS_I,
  output logic [1:0] DQS_O,
  output logic DQS_OE,
  input wire logic [1:0] DM_I,
  output logic RDQS_O,
  output logic RDQS_OE,
  output logic TERM_ON
);
  import dims_pkg::*;

  localparam int MEM_RW = MEM_AW - 6;
  localparam int MEM_DEPTH = 1 << MEM_AW;

  if (MEM_AW < 7 || MEM_AW > 14) begin : g_bad_aw
    $error("dims_top: MEM_AW must lie in 7..14");
  end

  typedef struct packed {
    logic ck_d;
    logic dqs_d;
    dims_init_e init;
    logic [7:0] dll_cnt;
    logic [ROW_W-1:0] mr;
    logic [ROW_W-1:0] emr1;
    logic [ROW_W-1:0] emr2;
    logic [ROW_W-1:0] emr3;
    logic [3:0] bank_open;
    logic [3:0][ROW_W-1:0] row;
    logic bst_act;
    logic bst_wr;
    logic bst_ap;
    logic [1:0] bst_bank;
    logic [ROW_W-1:0] bst_row;
    logic [COL_W-1:0] bst_col;
    logic [2:0] beat;
    logic [3:0] rl_cnt;
    logic [DQ_W-1:0] dq_o;
    logic dqs_o;
    logic rd_oe;
    logic term_on;
    logic link_en;
    logic seq_err;
    logic early_err;
    logic [15:0] mask_cnt;
    logic ack;
    logic [31:0] rdata;
  } dims_state_s;

  dims_state_s s_r;
  dims_state_s s_nxt;

  // ==========================================================
  // input synchronisers
  logic [LINK_W-1:0] link_s;
  logic [DATA_W-1:0] data_s;

  dims_sync #(.W(LINK_W)) u_link_sync (
    .clk(MCLK),
    .rst_n(RESET_N),
    .d({CK, CKE, CS_N, RAS_N, CAS_N, WE_N, BA, A, ODT}),
    .q(link_s)
  );

  dims_sync #(.W(DATA_W)) u_data_sync (
    .clk(MCLK),
    .rst_n(RESET_N),
    .d({DQS_I, DM_I, DQ_I}),
    .q(data_s)
  );

  logic ck_s;
  logic cke_s;
  logic cs_n_s;
  dims_cmd_e cmd;
  logic [1:0] ba_s;
  logic [ROW_W-1:0] a_s;
  logic odt_s;
  logic dqs_s;
  logic [1:0] dm_s;
  logic [DQ_W-1:0] dq_s;

  assign ck_s = link_s[22];
  assign cke_s = link_s[21];
  assign cs_n_s = link_s[20];
  assign cmd = dims_cmd_e'(link_s[19:17]);
  assign ba_s = link_s[16:15];
  assign a_s = link_s[14:1];
  assign odt_s = link_s[0];
  // upper strobe is taken to move with the lower one
  assign dqs_s = data_s[18];
  assign dm_s = data_s[17:16];
  assign dq_s = data_s[15:0];

  // ==========================================================
  // derived controls
  logic ck_rise;
  logic ck_edge;
  logic dqs_edge;
  logic cmd_vld;
  logic ready;
  logic bl8;
  logic [2:0] last_beat;
  logic [3:0] rl;
  logic rtt_en;
  logic rdqs_mode;
  logic wr_beat;
  logic rd_beat;
  logic [1:0] lane_we;
  logic [COL_W-1:0] cur_col;
  logic [MEM_AW-1:0] mem_idx;
  logic [DQ_W-1:0] rd_word;

  assign ck_rise = ck_s & ~s_r.ck_d;
  assign ck_edge = ck_s ^ s_r.ck_d;
  assign dqs_edge = dqs_s ^ s_r.dqs_d;
  assign cmd_vld = ck_rise & cke_s & ~cs_n_s & s_r.link_en;
  assign ready = (s_r.init == I_READY);
  assign bl8 = (s_r.mr[MR_BL_LSB+:3] == MR_BL8_CODE);
  assign last_beat = bl8 ? 3'h7 : 3'h3;
  assign rl = {1'b0, s_r.mr[MR_CL_LSB+:3]} + {1'b0, s_r.emr1[EMR_AL_LSB+:3]};
  assign rtt_en = s_r.emr1[EMR_RTT0] | s_r.emr1[EMR_RTT1];
  assign rdqs_mode = X8 & s_r.emr1[EMR_RDQS];
  assign wr_beat = dqs_edge & s_r.bst_act & s_r.bst_wr;
  assign rd_beat = ck_edge & s_r.bst_act & ~s_r.bst_wr & (s_r.rl_cnt == 4'h0);

  dims_burst_col #(.CW(COL_W)) u_col (
    .start_col(s_r.bst_col),
    .beat(s_r.beat),
    .bl8(bl8),
    .interleave(s_r.mr[MR_BT]),
    .col(cur_col)
  );

  assign mem_idx = {s_r.bst_bank, s_r.bst_row[MEM_RW-1:0], cur_col[3:0]};

  // ==========================================================
  // storage array, one memory per byte lane
  for (genvar g = 0; g < 2; g++) begin : g_lane
    logic [7:0] mem [0:MEM_DEPTH-1];
    assign lane_we[g] = wr_beat & (rdqs_mode | ~dm_s[g]) & ((g == 0) | ~X8);
    always_ff @(posedge MCLK) begin
      if (lane_we[g]) begin
        mem[mem_idx] <= dq_s[g*8+:8];
      end
    end
    assign rd_word[g*8+:8] = mem[mem_idx];
  end

  // ==========================================================
  // next-state logic
  logic bus_req;
  logic pre_all;

  assign bus_req = AVS_READ | AVS_WRITE;
  assign pre_all = (cmd == CMD_PRE) & a_s[A_AP];

  always_comb begin
    s_nxt = s_r;
    s_nxt.ck_d = ck_s;
    s_nxt.dqs_d = dqs_s;
    // register bus: wait one cycle, then answer
    s_nxt.ack = bus_req & ~s_r.ack;
    if (bus_req & ~s_r.ack) begin
      case (AVS_ADDRESS)
        REG_CTRL: s_nxt.rdata = {31'h0, s_r.link_en};
        REG_STATUS: s_nxt.rdata = {20'h0, s_r.init, 1'b0, s_r.bst_act, rdqs_mode,
                                   (s_r.dll_cnt == DLL_LOCK_CK), s_r.term_on,
                                   s_r.early_err, s_r.seq_err, ready};
        REG_MR: s_nxt.rdata = {18'h0, s_r.mr};
        REG_EMR1: s_nxt.rdata = {18'h0, s_r.emr1};
        REG_EMR2: s_nxt.rdata = {18'h0, s_r.emr2};
        REG_EMR3: s_nxt.rdata = {18'h0, s_r.emr3};
        REG_MASKCNT: s_nxt.rdata = {16'h0, s_r.mask_cnt};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    if (AVS_WRITE & s_r.ack) begin
      if (AVS_ADDRESS == REG_CTRL) begin
        s_nxt.link_en = AVS_WRITEDATA[CTRL_LINK_EN];
      end
      if (AVS_ADDRESS == REG_STATUS) begin
        if (AVS_WRITEDATA[ST_SEQ_ERR]) begin
          s_nxt.seq_err = 1'b0;
        end
        if (AVS_WRITEDATA[ST_EARLY_ERR]) begin
          s_nxt.early_err = 1'b0;
        end
      end
    end
    s_nxt.term_on = odt_s & rtt_en;
    if (ck_rise && s_r.dll_cnt != DLL_LOCK_CK) begin
      s_nxt.dll_cnt = s_r.dll_cnt + 8'h01;
    end
    if (s_r.init == I_PWR && cke_s) begin
      s_nxt.init = I_PALL1;
    end
    if (cmd_vld && !ready && (cmd == CMD_MRS || cmd == CMD_REF || cmd == CMD_PRE)) begin
      s_nxt.seq_err = 1'b1;
      case (s_r.init)
        I_PALL1: if (pre_all) begin
          s_nxt.init = I_EMR2;
          s_nxt.seq_err = s_r.seq_err;
        end
        I_EMR2: if (cmd == CMD_MRS && ba_s == BA_EMR2) begin
          s_nxt.init = I_EMR3;
          s_nxt.seq_err = s_r.seq_err;
        end
        I_EMR3: if (cmd == CMD_MRS && ba_s == BA_EMR3) begin
          s_nxt.init = I_EMR1;
          s_nxt.seq_err = s_r.seq_err;
        end
        I_EMR1: if (cmd == CMD_MRS && ba_s == BA_EMR1 && !a_s[A_DLL_DIS] && !a_s[A_RSV12]) begin
          s_nxt.init = I_MRDLL;
          s_nxt.seq_err = s_r.seq_err;
        end
        I_MRDLL: if (cmd == CMD_MRS && ba_s == BA_MR && a_s[A_DLL_RST]) begin
          s_nxt.init = I_PALL2;
          s_nxt.seq_err = s_r.seq_err;
        end
        I_PALL2: if (pre_all) begin
          s_nxt.init = I_REF1;
          s_nxt.seq_err = s_r.seq_err;
        end
        I_REF1: if (cmd == CMD_REF) begin
          s_nxt.init = I_REF2;
          s_nxt.seq_err = s_r.seq_err;
        end
        I_REF2: if (cmd == CMD_REF) begin
          s_nxt.init = I_MROP;
          s_nxt.seq_err = s_r.seq_err;
        end
        I_MROP: if (cmd == CMD_REF) begin
          s_nxt.seq_err = s_r.seq_err;
        end else if (cmd == CMD_MRS && ba_s == BA_MR && !a_s[A_DLL_RST]) begin
          s_nxt.init = I_OCD;
          s_nxt.seq_err = s_r.seq_err;
        end
        I_OCD: if (cmd == CMD_MRS && ba_s == BA_EMR1 && s_r.dll_cnt == DLL_LOCK_CK) begin
          s_nxt.seq_err = s_r.seq_err;
          if (a_s[EMR_OCD_LSB+:3] == OCD_EXIT) begin
            s_nxt.init = I_READY;
          end
        end
        default: s_nxt.seq_err = 1'b1;
      endcase
    end
    // mode writes touch only the mode registers and, with DLL reset set, the DLL lock counter
    if (cmd_vld && cmd == CMD_MRS) begin
      case (ba_s)
        BA_MR: s_nxt.mr = a_s;
        BA_EMR1: s_nxt.emr1 = a_s;
        BA_EMR2: s_nxt.emr2 = a_s;
        default: s_nxt.emr3 = a_s;
      endcase
      if (ba_s == BA_MR && a_s[A_DLL_RST]) begin
        s_nxt.dll_cnt = 8'h00;
      end
    end
    if (cmd_vld && cmd == CMD_PRE) begin
      if (a_s[A_AP]) begin
        s_nxt.bank_open = 4'h0;
      end else begin
        s_nxt.bank_open[ba_s] = 1'b0;
      end
    end
    if (cmd_vld && cmd == CMD_ACT) begin
      if (ready) begin
        s_nxt.bank_open[ba_s] = 1'b1;
        s_nxt.row[ba_s] = a_s;
      end else begin
        s_nxt.early_err = 1'b1;
      end
    end
    if (cmd_vld && (cmd == CMD_WR || cmd == CMD_RD)) begin
      if (!ready) begin
        s_nxt.early_err = 1'b1;
      end else if (s_r.bank_open[ba_s] && !s_r.bst_act) begin
        s_nxt.bst_act = 1'b1;
        s_nxt.bst_wr = (cmd == CMD_WR);
        s_nxt.bst_ap = a_s[A_AP];
        s_nxt.bst_bank = ba_s;
        s_nxt.bst_row = s_r.row[ba_s];
        s_nxt.bst_col = a_s[COL_W-1:0];
        s_nxt.beat = 3'h0;
        s_nxt.rl_cnt = (cmd == CMD_RD) ? rl : 4'h0;
      end
    end
    if (wr_beat) begin
      s_nxt.beat = s_r.beat + 3'h1;
      if (lane_we != ({~X8, 1'b1})) begin
        s_nxt.mask_cnt = s_r.mask_cnt + 16'h0001;
      end
      if (s_r.beat == last_beat) begin
        s_nxt.bst_act = 1'b0;
        if (s_r.bst_ap) begin
          s_nxt.bank_open[s_r.bst_bank] = 1'b0;
        end
      end
    end
    // read latency, then one beat per link clock edge
    if (ck_edge) begin
      s_nxt.rd_oe = 1'b0;
    end
    if (ck_rise && s_r.bst_act && !s_r.bst_wr && s_r.rl_cnt != 4'h0) begin
      s_nxt.rl_cnt = s_r.rl_cnt - 4'h1;
    end
    if (rd_beat) begin
      s_nxt.dq_o = rd_word;
      s_nxt.dqs_o = ck_s;
      s_nxt.rd_oe = 1'b1;
      s_nxt.beat = s_r.beat + 3'h1;
      if (s_r.beat == last_beat) begin
        s_nxt.bst_act = 1'b0;
        if (s_r.bst_ap) begin
          s_nxt.bank_open[s_r.bst_bank] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_r <= '0;
      s_r.link_en <= CTRL_LINK_EN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign AVS_WAITREQUEST = bus_req & ~s_r.ack;
  assign AVS_READDATA = s_r.rdata;
  assign DQ_O = s_r.dq_o;
  assign DQ_OE = s_r.rd_oe;
  assign DQS_O = {2{s_r.dqs_o}};
  assign DQS_OE = s_r.rd_oe;
  // shared pin drives the read strobe
  assign RDQS_O = s_r.dqs_o;
  assign RDQS_OE = s_r.rd_oe & rdqs_mode;
  assign TERM_ON = s_r.term_on;

  // ==========================================================
  // assertions
  a_mask_drops_low: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (wr_beat && dm_s[0] && !rdqs_mode) |-> !lane_we[0])
    else $error("masked low byte was written");
  a_beat_each_edge: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (wr_beat && s_r.beat != last_beat) |=> (s_r.beat == $past(s_r.beat) + 3'h1))
    else $error("strobe edge did not advance the write beat");
  a_lane_independent: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (!X8 && wr_beat && !dm_s[1] && dm_s[0] && !rdqs_mode) |-> (lane_we == 2'h2))
    else $error("upper lane not independent of lower mask");
  a_rdqs_no_mask: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (wr_beat && rdqs_mode) |-> lane_we[0])
    else $error("mask applied while pin is read strobe");
  a_odt_ignored: assert property (@(posedge MCLK) disable iff (!RESET_N)
    s_r.term_on |-> ($past(odt_s) && $past(rtt_en)))
    else $error("termination on without enable");
  a_burst_ends: assert property (@(posedge MCLK) disable iff (!RESET_N)
    ((wr_beat || rd_beat) && s_r.beat == last_beat) |=> !s_r.bst_act)
    else $error("burst did not end after programmed length");
  a_act_opens_row: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (cmd_vld && cmd == CMD_ACT && ready) |=>
      (s_r.bank_open[$past(ba_s)] && s_r.row[$past(ba_s)] == $past(a_s)))
    else $error("activate did not open the row");
  a_ap_closes_bank: assert property (@(posedge MCLK) disable iff (!RESET_N)
    ((wr_beat || rd_beat) && s_r.beat == last_beat && s_r.bst_ap) |=>
      !s_r.bank_open[$past(s_r.bst_bank)])
    else $error("auto-precharge did not close the bank");
  a_start_column: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (s_r.bst_act && s_r.beat == 3'h0) |-> (cur_col == s_r.bst_col))
    else $error("burst did not start at the given column");
  a_mrs_keeps_array: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (cmd_vld && cmd == CMD_MRS && !s_r.bst_act) |-> (lane_we == 2'h0))
    else $error("mode write disturbed the array");
  a_early_refused: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (cmd_vld && !ready && (cmd == CMD_RD || cmd == CMD_WR || cmd == CMD_ACT)) |=>
      (s_r.early_err && s_r.bank_open == $past(s_r.bank_open)))
    else $error("traffic before initialisation was not refused");
endmodule

// >>> tb/dims_ctl_model.sv
// behavioural DDR2 controller: link clock, commands, write strobes and data
`timescale 1ns/1ps
module dims_ctl_model
  import dims_pkg::*;
(
  output logic ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [13:0] a,
  output logic odt,
  output logic [15:0] dq,
  output logic [1:0] dqs,
  output logic [1:0] dm
);
  // ==========================================================
  // power-up levels and free-running link clock
  // cke and odt low
  initial begin
    {ck, cke, odt, ba, a, dq, dqs, dm} = '0;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    #137;
    forever #400 ck = ~ck;
  end

  // ==========================================================
  // one command, then nop cycles; pins change on the falling edge
  task automatic cmd(input dims_cmd_e c, input logic [1:0] b, input logic [13:0] ad);
    @(negedge ck);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    ba <= b;
    a <= ad;
    @(negedge ck);
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= CMD_NOP;
    ba <= ~b;
    a <= ~ad;
    @(negedge ck);
  endtask

  task automatic init(input logic [13:0] mr, input logic [13:0] emr1);
    #200_000;
    @(negedge ck);
    cke <= 1'b1;
    @(negedge ck);
    cmd(CMD_PRE, 2'h0, 14'h0400);
    cmd(CMD_MRS, BA_EMR2, 14'h0000);
    cmd(CMD_MRS, BA_EMR3, 14'h0000);
    cmd(CMD_MRS, BA_EMR1, emr1);
    cmd(CMD_MRS, BA_MR, mr | 14'h0100);
    cmd(CMD_PRE, 2'h0, 14'h0400);
    cmd(CMD_REF, 2'h0, 14'h0000);
    cmd(CMD_REF, 2'h0, 14'h0000);
    cmd(CMD_MRS, BA_MR, mr);
    repeat (200) @(negedge ck);
    // ocd default then exit, all fields repeated
    cmd(CMD_MRS, BA_EMR1, emr1 | 14'h0380);
    cmd(CMD_MRS, BA_EMR1, emr1);
  endtask

  // one mask per beat, strobe centred in data
  task automatic wr_burst(input logic [15:0] d[4], input logic [1:0] m[4]);
    for (int i = 0; i < 4; i++) begin
      dq <= d[i];
      dm <= m[i];
      @(posedge ck);
      dqs <= ~dqs;
      @(negedge ck);
    end
    dq <= ~dq;
  endtask
endmodule

// >>> tb/dims_tb_top.sv
// testbench: register access, init sequence, masked writes, burst reads, odt
`timescale 1ns/1ps
module dims_tb_top;
  import dims_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [AVS_AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, ck, cke, cs_n, ras_n, cas_n, we_n, odt;
  logic [1:0] ba, dqs_m, dm, dqs_o;
  logic [13:0] a;
  logic [15:0] dq_m, dq_o;
  logic dq_oe, dqs_oe, term_on, oe_d, dqs_d;
  logic [15:0] rq[$];
  logic [15:0] mem_exp[4] = '{16'hA1A1, 16'hB222, 16'h33C3, 16'h4444};
  int miscompares = 0;
  int check_count = 0;
  wire [15:0] dq_i = dq_oe ? dq_o : dq_m;
  wire [1:0] dqs_i = dqs_oe ? dqs_o : dqs_m;

  always #50 mclk = ~mclk;

  dims_ctl_model u_ctl (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .a(a), .odt(odt), .dq(dq_m), .dqs(dqs_m), .dm(dm));

  dims_top DUT (.MCLK(mclk), .RESET_N(reset_n), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .CK(ck), .CKE(cke),
    .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .A(a), .ODT(odt),
    .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe), .DQS_I(dqs_i), .DQS_O(dqs_o),
    .DQS_OE(dqs_oe), .DM_I(dm), .RDQS_O(), .RDQS_OE(), .TERM_ON(term_on));

  // ==========================================================
  // read beats: one per strobe change while the device drives
  always @(posedge mclk) begin
    oe_d <= dq_oe;
    dqs_d <= dqs_o[0];
    if (dq_oe === 1'b1 && (oe_d !== 1'b1 || dqs_o[0] !== dqs_d)) begin
      rq.push_back(dq_o);
    end
  end

  // ==========================================================
  // tasks
  task automatic avs(input logic wr, input logic [4:0] ad, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge mclk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic rd_chk(input logic [13:0] ad, input int bt);
    rq.delete();
    u_ctl.cmd(CMD_RD, 2'h1, ad);
    while (rq.size() < 4) begin
      @(posedge mclk);
    end
    for (int k = 0; k < 4; k++) begin
      chk("read beat", {16'h0, mem_exp[bt ? (1 ^ k) : ((1 + k) % 4)]}, {16'h0, rq[k]});
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    #3_000_000;
    miscompares++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    avs(1'b0, REG_CTRL, 32'h0, q);
    chk("ctrl", 32'h1, q);
    avs(1'b0, REG_STATUS, 32'h0, q);
    chk("status", 32'h0, q);
    avs(1'b0, 5'h1C, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
    u_ctl.cke <= 1'b1;
    u_ctl.cmd(CMD_ACT, 2'h1, 14'h0005);
    tick(10);
    avs(1'b0, REG_STATUS, 32'h0, q);
    chk("early error", 32'h4, q & 32'h4);
    avs(1'b1, REG_STATUS, 32'h6, q);
    avs(1'b0, REG_STATUS, 32'h0, q);
    chk("error clear", 32'h0, q & 32'h6);
    u_ctl.cke <= 1'b0;
    $display("test early traffic done");
    u_ctl.init(14'h0032, 14'h0004);
    tick(10);
    avs(1'b0, REG_STATUS, 32'h0, q);
    chk("init status", 32'h0B11, q & 32'hF1F);
    avs(1'b0, REG_MR, 32'h0, q);
    chk("mode", 32'h32, q);
    avs(1'b0, REG_EMR1, 32'h0, q);
    chk("ext mode 1", 32'h4, q);
    $display("test init done");
    u_ctl.odt <= 1'b1;
    tick(10);
    chk("termination", 32'h1, {31'h0, term_on});
    u_ctl.cmd(CMD_MRS, BA_EMR1, 14'h0000);
    tick(10);
    chk("termination off", 32'h0, {31'h0, term_on});
    u_ctl.cmd(CMD_MRS, BA_EMR1, 14'h0004);
    u_ctl.odt <= 1'b0;
    $display("test odt done");
    u_ctl.cmd(CMD_ACT, 2'h1, 14'h0005);
    u_ctl.cmd(CMD_WR, 2'h1, 14'h0004);
    u_ctl.wr_burst('{16'h1111, 16'h2222, 16'h3333, 16'h4444}, '{2'h0, 2'h0, 2'h0, 2'h0});
    u_ctl.cmd(CMD_WR, 2'h1, 14'h0004);
    u_ctl.wr_burst('{16'hA1A1, 16'hB2B2, 16'hC3C3, 16'hD4D4}, '{2'h0, 2'h1, 2'h2, 2'h3});
    tick(20);
    avs(1'b0, REG_MASKCNT, 32'h0, q);
    chk("masked beats", 32'h3, q);
    for (int bt = 0; bt < 2; bt++) begin
      u_ctl.cmd(CMD_PRE, 2'h0, 14'h0400);
      u_ctl.cmd(CMD_MRS, BA_MR, 14'h0032 | 14'(bt << 3));
      u_ctl.cmd(CMD_ACT, 2'h1, 14'h0005);
      rd_chk(14'h0005 | 14'(bt << 10), bt);
    end
    rq.delete();
    u_ctl.cmd(CMD_RD, 2'h1, 14'h0005);
    tick(100);
    chk("closed bank read", 32'h0, rq.size());
    u_ctl.cmd(CMD_MRS, BA_MR, 14'h0033);
    u_ctl.cmd(CMD_ACT, 2'h1, 14'h0005);
    rq.delete();
    u_ctl.cmd(CMD_RD, 2'h1, 14'h0005);
    tick(100);
    chk("burst of eight", 32'h8, rq.size());
    $display("test bursts done");
    summarize();
  end
endmodule
